// ---- rtl/irm_pkg.sv ----
/*
 * Constants and types for the upper isochronous receive channel mask:
 * register offsets, control field positions, reset values, bus codes.
 * Assumes a 32-bit AHB-Lite bus with word-aligned registers.
 */
package irm_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  MASK_SET_OFS   = 8'h70;
    localparam logic [7:0]  MASK_CLEAR_OFS = 8'h74;
    localparam logic [7:0]  CONTROL_OFS    = 8'h90;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int          CTRL_LINK_BIT  = 0;
    localparam int          CTRL_SRST_BIT  = 1;

    // ------------------------------------------------------------------
    // Reset values, channel base and widths
    // ------------------------------------------------------------------
    localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
    localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;
    localparam logic [5:0]  CHAN_BASE      = 6'h20;
    localparam int          MASK_W         = 32;

    // ------------------------------------------------------------------
    // AHB codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ     = 2'h3;
    localparam logic        HRESP_OKAY     = 1'h0;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_SET,
        SEL_CLEAR,
        SEL_CTRL
    } irm_sel_t;

endpackage

// ---- rtl/irm_chan_filter.sv ----
/*
 * Channel filter: decides whether an isochronous packet on one of the
 * upper 32 channels is received. Purely combinational.
 * Assumes the caller registers the verdict and supplies a stable mask.
 */
`timescale 1ns/1ns

module irm_chan_filter (
    input  wire logic [31:0] mask,
    input  wire logic        link_connect_control,
    input  wire logic        pkt_valid,
    input  wire logic        pkt_iso,
    input  wire logic [5:0]  pkt_channel,
    output logic             accept,
    output logic             reject
);

    // ------------------------------------------------------------------
    // Bit select for a channel
    // ------------------------------------------------------------------
    function automatic logic chan_enabled(input logic [31:0] m, input logic [5:0] ch);
        logic [4:0] idx;
        idx = 5'(ch - irm_pkg::CHAN_BASE);   // bit n enables channel n+32
        return m[idx];
    endfunction

    logic upper;

    always_comb begin
        upper  = pkt_valid && pkt_iso && (pkt_channel >= irm_pkg::CHAN_BASE);
        // Disconnected link drops everything
        accept = upper && link_connect_control && chan_enabled(mask, pkt_channel);
        reject = upper && !(link_connect_control && chan_enabled(mask, pkt_channel));
    end

endmodule

// ---- rtl/irm_top.sv ----
/*
 * Upper isochronous receive channel mask (channels 32..63) with an
 * AHB-Lite register slave and the receive filter verdict for packets.
 * Assumes one clock, synchronous active-low reset, single word transfers,
 * and packet descriptors produced by logic on the same clock.
 */
// Our own choice: the AHB-Lite slave port.
// Operation
// - Receive upper channel only when bit set
// - Write 1s: 70h sets, 74h clears
// - Reads of either address return mask
// - Bit 31 is channel 63, descending
// - Bit 0 enables channel 32
// - Link disconnected: no packets received

`timescale 1ns/1ns

module irm_top (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Receive path
    input  wire logic        pkt_valid,
    input  wire logic        pkt_iso,
    input  wire logic [5:0]  pkt_channel,
    output logic             pkt_accept,
    output logic             pkt_reject,
    output logic [31:0]      iso_rx_mask,
    output logic             link_connect_control
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]       mask;
        logic              link_en;
        logic              wr_pend;
        irm_pkg::irm_sel_t wr_sel;
        logic [31:0]       rdata;
        logic              ready;
        logic              resp;
        logic              accept;
        logic              reject;
    } irm_state_t;

    irm_state_t st_reg;
    irm_state_t st_next;

    // Reset image of all state
    localparam irm_state_t ST_RESET = '{
        mask:    irm_pkg::MASK_RESET,
        link_en: 1'b0,
        wr_pend: 1'b0,
        wr_sel:  irm_pkg::SEL_NONE,
        rdata:   irm_pkg::RDATA_RESET,
        ready:   1'b1,
        resp:    irm_pkg::HRESP_OKAY,
        accept:  1'b0,
        reject:  1'b0
    };

    logic       filt_accept;
    logic       filt_reject;
    logic       addr_phase;
    logic [31:0] mask_after_wr;
    logic       link_after_wr;
    logic       srst_req;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic irm_pkg::irm_sel_t decode(input logic [31:0] a);
        irm_pkg::irm_sel_t s;
        s = irm_pkg::SEL_NONE;
        if (a[7:2] == irm_pkg::MASK_SET_OFS[7:2]) begin
            s = irm_pkg::SEL_SET;
        end else if (a[7:2] == irm_pkg::MASK_CLEAR_OFS[7:2]) begin
            s = irm_pkg::SEL_CLEAR;
        end else if (a[7:2] == irm_pkg::CONTROL_OFS[7:2]) begin
            s = irm_pkg::SEL_CTRL;
        end
        return s;
    endfunction

    // ------------------------------------------------------------------
    // Mask after a write data phase
    // ------------------------------------------------------------------
    function automatic logic [31:0] write_mask(input irm_pkg::irm_sel_t s,
                                               input logic [31:0]       m,
                                               input logic [31:0]       d);
        logic [31:0] r;
        r = m;
        if (s == irm_pkg::SEL_SET) begin
            r = m | d;
        end else if (s == irm_pkg::SEL_CLEAR) begin
            r = m & ~d;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Read data for a register
    // ------------------------------------------------------------------
    function automatic logic [31:0] read_word(input irm_pkg::irm_sel_t s,
                                              input logic [31:0]       m,
                                              input logic              l);
        logic [31:0] r;
        r = irm_pkg::RDATA_RESET;
        unique case (s)
            irm_pkg::SEL_SET, irm_pkg::SEL_CLEAR: begin
                r = m;
            end
            irm_pkg::SEL_CTRL: begin
                r[irm_pkg::CTRL_LINK_BIT] = l;
            end
            irm_pkg::SEL_NONE: begin
                r = irm_pkg::RDATA_RESET;
            end
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Packet filter
    // ------------------------------------------------------------------
    irm_chan_filter u_filter (
        .mask                 (st_reg.mask),
        .link_connect_control (st_reg.link_en),
        .pkt_valid            (pkt_valid),
        .pkt_iso              (pkt_iso),
        .pkt_channel          (pkt_channel),
        .accept               (filt_accept),
        .reject               (filt_reject)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next       = st_reg;
        addr_phase    = hsel && hready &&
                        (htrans == irm_pkg::HTRANS_NONSEQ || htrans == irm_pkg::HTRANS_SEQ);
        mask_after_wr = st_reg.mask;
        link_after_wr = st_reg.link_en;
        srst_req      = 1'b0;

        // Data phase of a pending write
        if (st_reg.wr_pend) begin
            unique case (st_reg.wr_sel)
                irm_pkg::SEL_SET, irm_pkg::SEL_CLEAR: begin
                    mask_after_wr = write_mask(st_reg.wr_sel, st_reg.mask, hwdata);
                end
                irm_pkg::SEL_CTRL: begin
                    link_after_wr = hwdata[irm_pkg::CTRL_LINK_BIT];
                    srst_req      = hwdata[irm_pkg::CTRL_SRST_BIT];
                end
                irm_pkg::SEL_NONE: begin
                    mask_after_wr = st_reg.mask;
                end
            endcase
        end

        // Software reset returns mask and link control to reset values
        if (srst_req) begin
            mask_after_wr = irm_pkg::MASK_RESET;
            link_after_wr = 1'b0;
        end

        st_next.mask    = mask_after_wr;
        st_next.link_en = link_after_wr;
        st_next.wr_pend = 1'b0;
        st_next.wr_sel  = irm_pkg::SEL_NONE;
        st_next.rdata   = irm_pkg::RDATA_RESET;
        st_next.ready   = 1'b1;
        st_next.resp    = irm_pkg::HRESP_OKAY;

        // Address phase: latch write target or fetch read data
        if (addr_phase) begin
            if (hwrite) begin
                st_next.wr_pend = 1'b1;
                st_next.wr_sel  = decode(haddr);
            end else begin
                st_next.rdata = read_word(decode(haddr), mask_after_wr, link_after_wr);
            end
        end

        st_next.accept = filt_accept;
        st_next.reject = filt_reject;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_reg <= ST_RESET;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hreadyout            = st_reg.ready;
    assign hrdata               = st_reg.rdata;
    assign hresp                = st_reg.resp;
    assign pkt_accept           = st_reg.accept;
    assign pkt_reject           = st_reg.reject;
    assign iso_rx_mask          = st_reg.mask;
    assign link_connect_control = st_reg.link_en;

endmodule

// ---- tb/irm_checker.sv ----
/* Port checker for irm_top.
   Assumes a bind onto irm_top, one clock, synchronous reset. */
`timescale 1ns/1ns
module irm_checker (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        pkt_valid,
    input wire logic        pkt_iso,
    input wire logic [5:0]  pkt_channel,
    input wire logic        pkt_accept,
    input wire logic        pkt_reject,
    input wire logic [31:0] iso_rx_mask,
    input wire logic        link_connect_control
);
    // ------------------------------------------------------------
    // Data phase tracking
    // ------------------------------------------------------------
    logic ws;
    logic wc;
    logic rd;
    logic hit;
    wire  tk = clk_en && hsel && hready && htrans[1];
    wire  up = clk_en && pkt_valid && pkt_iso && pkt_channel[5];
    always_ff @(posedge mclk) begin
        if (clk_en) begin
            ws  <= reset_n && tk && hwrite && haddr[7:2] == irm_pkg::MASK_SET_OFS[7:2];
            wc  <= reset_n && tk && hwrite && haddr[7:2] == irm_pkg::MASK_CLEAR_OFS[7:2];
            rd  <= reset_n && tk && !hwrite && (haddr[7:2] == irm_pkg::MASK_SET_OFS[7:2] ||
                   haddr[7:2] == irm_pkg::MASK_CLEAR_OFS[7:2]);
            hit <= iso_rx_mask[pkt_channel[4:0]] && link_connect_control;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_filt; up |=> pkt_accept == hit && pkt_reject == !hit; endproperty
    a_filt: assert property (p_filt) else $error("verdict wrong");
    property p_top; up && pkt_channel == 6'h3f && iso_rx_mask[31] && link_connect_control
        |=> pkt_accept; endproperty
    a_top: assert property (p_top) else $error("channel 63 lost");
    property p_base; up && pkt_channel == 6'h20 && !iso_rx_mask[0]
        |=> pkt_reject ##1 !pkt_reject; endproperty
    a_base: assert property (p_base) else $error("channel 32 wrong");
    property p_link; up && !link_connect_control |=> !pkt_accept; endproperty
    a_link: assert property (p_link) else $error("accepted while off");
    property p_set; ws && clk_en |=> iso_rx_mask == ($past(iso_rx_mask) | $past(hwdata));
    endproperty
    a_set: assert property (p_set) else $error("set wrong");
    property p_clr; wc && clk_en |=> iso_rx_mask == ($past(iso_rx_mask) & ~$past(hwdata));
    endproperty
    a_clr: assert property (p_clr) else $error("clear wrong");
    property p_keep; (ws || wc) && clk_en
        |=> ((iso_rx_mask ^ $past(iso_rx_mask)) & ~$past(hwdata)) == 32'h0000_0000; endproperty
    a_keep: assert property (p_keep) else $error("zero bit changed");
    property p_rdat; rd |-> hrdata == iso_rx_mask ##1 $stable(iso_rx_mask); endproperty
    a_rdat: assert property (p_rdat) else $error("read wrong");
    c_wr_rd: cover property (ws ##2 rd);
    c_acc: cover property (up ##1 pkt_accept);
    c_off: cover property (up && !link_connect_control);
endmodule
bind irm_top irm_checker chk_u (.mclk, .reset_n, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .pkt_valid, .pkt_iso, .pkt_channel, .pkt_accept, .pkt_reject,
    .iso_rx_mask, .link_connect_control);

// ---- tb/irm_tb_top.sv ----
/* Self-checking bench for irm_top: mask access over AHB-Lite and
   filter verdicts. Assumes hreadyout is the bus hready. */
`timescale 1ns/1ns
module irm_tb_top;
    logic mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, hsel = 1'b1, hwrite = 1'b0;
    logic pkt_valid = 1'b0, pkt_iso = 1'b0, hreadyout, hresp;
    logic pkt_accept, pkt_reject, link_connect_control;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, iso_rx_mask, q, m;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [5:0]  pkt_channel = 6'h00;
    int          errors = 0;
    int          compares = 0;
    irm_top dut_u (.mclk, .reset_n, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pkt_valid, .pkt_iso,
        .pkt_channel, .pkt_accept, .pkt_reject, .iso_rx_mask, .link_connect_control);
    always #50 mclk = ~mclk;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task end_of_test;
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_pkt(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: verdict %b exp %b", $time, got, exp);
        end
    endtask
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            errors++;
            end_of_test;
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= irm_pkg::HTRANS_NONSEQ;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
        chk(32'(hresp), 32'(irm_pkg::HRESP_OKAY));
    endtask
    task pkt(input logic [5:0] ch, input logic iso, input logic [1:0] e);
        pkt_channel <= ch;
        pkt_iso     <= iso;
        pkt_valid   <= 1'b1;
        @(posedge mclk);
        pkt_valid   <= 1'b0;
        @(posedge mclk);
        chk_pkt({pkt_accept, pkt_reject}, e);
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        xfer(1'b1, irm_pkg::CONTROL_OFS, 32'h0000_0001);
        xfer(1'b1, 8'h70, 32'h8000_0001);
        xfer(1'b0, 8'h70, 32'h0000_0000);
        chk(q, 32'h8000_0001);
        xfer(1'b1, 8'h70, 32'h0000_00f0);
        xfer(1'b0, 8'h74, 32'h0000_0000);
        chk(q, 32'h8000_00f1);
        xfer(1'b1, 8'h74, 32'h0000_0031);
        xfer(1'b0, 8'h70, 32'h0000_0000);
        chk(q, 32'h8000_00c0);
        xfer(1'b0, 8'h74, 32'h0000_0000);
        chk(q, 32'h8000_00c0);
        xfer(1'b0, 8'h40, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        xfer(1'b1, 8'h70, 32'h0555_0000);
        m = 32'h8555_00c0;
        for (int i = 0; i < 32; i++) begin
            pkt(6'(i + 32), 1'b1, {m[i], !m[i]});
        end
        chk(iso_rx_mask, m);
        pkt(6'h07, 1'b1, 2'b00);
        pkt(6'h3f, 1'b0, 2'b00);
        // Frozen clock enable: packet must leave no verdict
        clk_en <= 1'b0;
        pkt(6'h3f, 1'b1, 2'b00);
        clk_en <= 1'b1;
        pkt(6'h3f, 1'b1, 2'b10);
        xfer(1'b1, irm_pkg::CONTROL_OFS, 32'h0000_0000);
        pkt(6'h3f, 1'b1, 2'b01);
        // Link control read back, then software reset
        xfer(1'b1, irm_pkg::CONTROL_OFS, 32'h0000_0001);
        xfer(1'b0, irm_pkg::CONTROL_OFS, 32'h0000_0000);
        chk(q, 32'h0000_0001);
        xfer(1'b1, irm_pkg::CONTROL_OFS, 32'h0000_0003);
        xfer(1'b0, 8'h74, 32'h0000_0000);
        chk(q, irm_pkg::MASK_RESET);
        xfer(1'b0, irm_pkg::CONTROL_OFS, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        chk(32'(link_connect_control), 32'h0000_0000);
        pkt(6'h3f, 1'b1, 2'b01);
        end_of_test;
    end
endmodule
